// [hdl/cpl_pkg.sv]
package cpl_pkg;

	// register bus geometry
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;

	// byte addresses of the register words
	localparam logic [ADDR_W-1:0] KEY_OFS = 4'h0;
	localparam logic [ADDR_W-1:0] STATUS_OFS = 4'h4;
	localparam logic [ADDR_W-1:0] CORE_OFS = 4'h8;
	localparam logic [ADDR_W-1:0] INTCTL_OFS = 4'hc;

	// field positions
	localparam int KEY_LSB = 0;
	localparam int KEY_W = 8;
	localparam int LEVEL_LOW_LSB = 5;
	localparam int LEVEL_LOW_W = 3;
	localparam int HIGH_BIT_POS = 3;
	localparam int NEST_DIS_POS = 15;
	localparam int LEVEL_W = 4;

	// reset values
	localparam logic [LEVEL_LOW_W-1:0] LEVEL_LOW_RST = 3'h0;
	localparam logic HIGH_BIT_RST = 1'b0;
	localparam logic NEST_DIS_RST = 1'b0;
	localparam logic [KEY_W-1:0] KEY_RST = 8'h00;

	// low field value that shuts out user interrupts
	localparam logic [LEVEL_LOW_W-1:0] LEVEL_LOW_ALL_ONES = 3'h7;

	// bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	// complete state of the block
	typedef struct packed {
		logic aw_held;
		logic [ADDR_W-1:0] aw_addr;
		logic w_held;
		logic [DATA_W-1:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [DATA_W-1:0] rdata;
		logic [LEVEL_LOW_W-1:0] level_low;
		logic high_bit;
		logic nest_dis;
		logic [KEY_W-1:0] key;
		logic key_stb;
	} cpl_state_s;

endpackage

// [hdl/cpl_priority_level.sv]
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module cpl_priority_level
(
	input wire logic ref_clk,
	input wire logic reset,
	// axi4-lite write address
	input wire logic [cpl_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [cpl_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [cpl_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [cpl_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// level load from the core (exception entry or return)
	input wire logic level_load,
	input wire logic [cpl_pkg::LEVEL_W-1:0] level_load_value,
	// user interrupt request from the interrupt source logic
	input wire logic irq_pending,
	input wire logic [cpl_pkg::LEVEL_W-1:0] irq_priority,
	output logic irq_take,
	output logic user_irq_masked,
	// current level and unlock key toward the rest of the chip
	output logic [cpl_pkg::LEVEL_W-1:0] cpu_priority_level,
	output logic [cpl_pkg::KEY_W-1:0] flash_unlock_key,
	output logic flash_unlock_key_stb
);

	// all state of the block lives in one struct; the next value is built combinationally
	cpl_pkg::cpl_state_s state_r;
	cpl_pkg::cpl_state_s state_nxt;

	// one handshake per request channel: write address, write data and read address
	logic aw_fire;
	logic w_fire;
	logic ar_fire;

	// a write goes ahead once both its address and its data are known
	logic have_aw;
	logic have_w;
	logic do_write;
	logic [cpl_pkg::ADDR_W-1:0] wr_addr;
	logic [cpl_pkg::DATA_W-1:0] wr_data;
	logic [3:0] wr_strb;

	// decoded write selects
	logic wr_low_open;
	logic wr_high_clear;

	// read word and whether its address decoded
	logic [cpl_pkg::DATA_W-1:0] rd_word;
	logic rd_hit;

	// current level and the causes that shut out user requests
	logic [cpl_pkg::LEVEL_W-1:0] level;
	logic mask_high;
	logic mask_ones;
	logic prio_above;
	logic masked;

	// handshakes: each address/data channel holds one item until the write is done
	// the readies depend on registered state only, so no path runs from a valid to a ready
	// one write and one read may be under way at once, independent of each other
	assign s_axi_awready = !state_r.aw_held && !state_r.bvalid;
	assign s_axi_wready = !state_r.w_held && !state_r.bvalid;
	assign s_axi_arready = !state_r.rvalid;
	assign aw_fire = s_axi_awvalid && s_axi_awready;
	assign w_fire = s_axi_wvalid && s_axi_wready;
	assign ar_fire = s_axi_arvalid && s_axi_arready;

	// the half that arrived first comes from its held copy, the other straight from the bus
	// no synchroniser here: every input comes from logic on this same clock
	assign have_aw = state_r.aw_held || aw_fire;
	assign have_w = state_r.w_held || w_fire;
	assign do_write = have_aw && have_w;
	assign wr_addr = state_r.aw_held ? state_r.aw_addr : s_axi_awaddr;
	assign wr_data = state_r.w_held ? state_r.w_data : s_axi_wdata;
	assign wr_strb = state_r.w_held ? state_r.w_strb : s_axi_wstrb;

	// write selects; only byte lane 0 carries the level fields
	// with nesting disabled the low level bits behave as read-only to software
	assign wr_low_open = wr_strb[0] && !state_r.nest_dis;
	// the high bit is clear-only from software: writing a zero clears it, a one is ignored
	assign wr_high_clear = wr_strb[0] && !wr_data[cpl_pkg::HIGH_BIT_POS];

	// full level: the high bit sits above the three low bits
	// the level only changes by a core load or a software write, never by itself
	assign level = {state_r.high_bit, state_r.level_low};
	assign cpu_priority_level = level;

	// any set high bit means level 8 to 15, all of which shut out user requests
	assign mask_high = state_r.high_bit;
	// all ones in the low field is level 7, or 15 together with the high bit
	assign mask_ones = (state_r.level_low == cpl_pkg::LEVEL_LOW_ALL_ONES);
	// both causes leave as one mask so the source logic need not know the encoding
	assign masked = mask_high || mask_ones;
	assign user_irq_masked = masked;

	// a request of equal priority waits; only a strictly higher one may interrupt
	assign prio_above = (irq_priority > level);
	// the strict compare alone would let priorities 8 to 15 through at level 7, hence the explicit mask
	assign irq_take = irq_pending && !masked && prio_above;

	// bus answers come straight from flip-flops
	// read data stays put after the handshake, which costs nothing and eases debugging
	assign s_axi_bvalid = state_r.bvalid;
	assign s_axi_bresp = state_r.bresp;
	assign s_axi_rvalid = state_r.rvalid;
	assign s_axi_rresp = state_r.rresp;
	assign s_axi_rdata = state_r.rdata;

	// key byte and its one-cycle strobe toward the flash controller
	assign flash_unlock_key = state_r.key;
	assign flash_unlock_key_stb = state_r.key_stb;

	// read decode; unlisted bits read zero
	// the address is decoded straight from the bus and the word is registered when it is taken
	always_comb
	begin
		rd_word = '0;
		rd_hit = 1'b1;
		unique case (s_axi_araddr)
			cpl_pkg::KEY_OFS:
			begin
				// the key is write-only, so a read never shows what was written
				rd_word = '0;
			end

			cpl_pkg::STATUS_OFS:
			begin
				// only the low level field is present in this status word
				rd_word[cpl_pkg::LEVEL_LOW_LSB +: cpl_pkg::LEVEL_LOW_W] = state_r.level_low;
			end

			cpl_pkg::CORE_OFS:
			begin
				// set exactly while the level is above seven
				rd_word[cpl_pkg::HIGH_BIT_POS] = state_r.high_bit;
			end

			cpl_pkg::INTCTL_OFS:
			begin
				// only the nesting disable bit exists in this word
				rd_word[cpl_pkg::NEST_DIS_POS] = state_r.nest_dis;
			end

			default:
			begin
				// unaligned or unused offsets answer with a decode error
				rd_hit = 1'b0;
			end
		endcase
	end

	// next-state logic
	always_comb
	begin
		// hold everything by default; the key strobe falls unless a key write renews it
		state_nxt = state_r;
		state_nxt.key_stb = 1'b0;

		// capture whichever of address and data arrives first
		// holding one half lets a master offer them in either order without stalling the other channel
		if (aw_fire && !do_write)
		begin
			state_nxt.aw_held = 1'b1;
			state_nxt.aw_addr = s_axi_awaddr;
		end

		if (w_fire && !do_write)
		begin
			state_nxt.w_held = 1'b1;
			state_nxt.w_data = s_axi_wdata;
			state_nxt.w_strb = s_axi_wstrb;
		end

		// register writes
		if (do_write)
		begin
			// both halves present: retire them and answer in the next cycle
			state_nxt.aw_held = 1'b0;
			state_nxt.w_held = 1'b0;
			state_nxt.bvalid = 1'b1;
			state_nxt.bresp = cpl_pkg::RESP_OKAY;
			// decode on the merged address so a late data beat still lands in the right word
			unique case (wr_addr)
				cpl_pkg::KEY_OFS:
				begin
					// no unlock sequence is judged here; the flash controller sees each byte with its strobe
					if (wr_strb[0])
					begin
						state_nxt.key = wr_data[cpl_pkg::KEY_LSB +: cpl_pkg::KEY_W];
						state_nxt.key_stb = 1'b1;
					end
				end

				cpl_pkg::STATUS_OFS:
				begin
					// with nesting disabled or byte lane 0 off, writes are dropped silently, the bus still answers okay
					// the other status bits are not part of this block
					if (wr_low_open)
					begin
						state_nxt.level_low = wr_data[cpl_pkg::LEVEL_LOW_LSB +: cpl_pkg::LEVEL_LOW_W];
					end
				end

				cpl_pkg::CORE_OFS:
				begin
					// software may only clear the high bit, never set it
					// setting it is left to the core, through a level load
					if (wr_high_clear)
					begin
						state_nxt.high_bit = 1'b0;
					end
				end

				cpl_pkg::INTCTL_OFS:
				begin
					// the nesting disable bit lives in byte lane 1
					if (wr_strb[1])
					begin
						state_nxt.nest_dis = wr_data[cpl_pkg::NEST_DIS_POS];
					end
				end

				default:
				begin
					// unmapped offset: nothing changes and the master gets a decode error
					state_nxt.bresp = cpl_pkg::RESP_DECERR;
				end
			endcase
		end

		// the response stands until the master takes it
		if (state_r.bvalid && s_axi_bready)
		begin
			state_nxt.bvalid = 1'b0;
		end

		// core load wins over a software write in the same cycle
		// exception entry and return move the whole level at once, high bit included
		// the load ignores nesting disable, which only guards software writes
		if (level_load)
		begin
			state_nxt.level_low = level_load_value[cpl_pkg::LEVEL_LOW_W-1:0];
			state_nxt.high_bit = level_load_value[cpl_pkg::LEVEL_W-1];
		end

		// reads: the word is captured when the address is taken and stands until rready
		if (ar_fire)
		begin
			state_nxt.rvalid = 1'b1;
			state_nxt.rdata = rd_word;
			// an unmapped read answers zero with a decode error
			state_nxt.rresp = rd_hit ? cpl_pkg::RESP_OKAY : cpl_pkg::RESP_DECERR;
		end
		else if (state_r.rvalid && s_axi_rready)
		begin
			state_nxt.rvalid = 1'b0;
		end
	end

	// state register; reset is asynchronous and loads constants only
	always_ff @(posedge ref_clk or posedge reset)
	begin
		if (reset)
		begin
			// clear the bus side first, then lay down the reset values field by field
			// both response channels start idle, so every ready is high right after reset
			state_r <= '0;
			state_r.level_low <= cpl_pkg::LEVEL_LOW_RST;
			state_r.high_bit <= cpl_pkg::HIGH_BIT_RST;
			state_r.nest_dis <= cpl_pkg::NEST_DIS_RST;
			state_r.key <= cpl_pkg::KEY_RST;
		end
		else
		begin
			state_r <= state_nxt;
		end
	end

endmodule

// [test/cpl_priority_level_asserts.sv]
`timescale 1ns/1ps
// watches masking, level load, take and bus hold from the top ports only
module cpl_asserts
(
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic level_load,
	input wire logic [3:0] level_load_value,
	input wire logic irq_pending,
	input wire logic [3:0] irq_priority,
	input wire logic irq_take,
	input wire logic user_irq_masked,
	input wire logic [3:0] cpu_priority_level,
	input wire logic flash_unlock_key_stb
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (reset);
	property p_seven; cpu_priority_level[2:0] == 3'h7 |-> user_irq_masked; endproperty
	a_seven: assert property (p_seven) else $error("all ones not masked");
	property p_high; cpu_priority_level[3] |-> user_irq_masked; endproperty
	a_high: assert property (p_high) else $error("high level not masked");
	property p_open; !cpu_priority_level[3] && cpu_priority_level[2:0] != 3'h7 |-> !user_irq_masked; endproperty
	a_open: assert property (p_open) else $error("low level masked");
	property p_take; irq_take |-> irq_pending && irq_priority > cpu_priority_level; endproperty
	a_take: assert property (p_take) else $error("take without cause");
	property p_give; irq_pending && !user_irq_masked && irq_priority > cpu_priority_level |-> irq_take; endproperty
	a_give: assert property (p_give) else $error("take missing");
	property p_load; level_load |=> cpu_priority_level == $past(level_load_value); endproperty
	a_load: assert property (p_load) else $error("level load lost");
	property p_stb; flash_unlock_key_stb |=> !flash_unlock_key_stb; endproperty
	a_stb: assert property (p_stb) else $error("key strobe too long");
	property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
	a_bhold: assert property (p_bhold) else $error("write response dropped");
endmodule
bind cpl_priority_level cpl_asserts i_chk
(
	.ref_clk(ref_clk),
	.reset(reset),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.level_load(level_load),
	.level_load_value(level_load_value),
	.irq_pending(irq_pending),
	.irq_priority(irq_priority),
	.irq_take(irq_take),
	.user_irq_masked(user_irq_masked),
	.cpu_priority_level(cpu_priority_level),
	.flash_unlock_key_stb(flash_unlock_key_stb)
);

// [test/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
	logic ref_clk = 1'h0;
	logic reset = 1'h1;
	logic [3:0] awa = 4'h0, ara = 4'h0, strb = 4'h0, llv = 4'h0, ipr = 4'h0, lvl;
	logic [31:0] wd = 32'h0, rdd;
	logic awv = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0, ll = 1'h0, ip = 1'h0;
	logic bv, rv, awr, wrd, arr, take, msk, stb;
	logic [1:0] bresp, rresp;
	logic [7:0] key;
	int n_fail = 0;
	int comparisons = 0;
	cpl_priority_level i_dut
	(
		.ref_clk(ref_clk), .reset(reset), .s_axi_awaddr(awa), .s_axi_awprot(3'h0), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(strb), .s_axi_wvalid(wv), .s_axi_wready(wrd),
		.s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arprot(3'h0),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdd), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
		.s_axi_rready(rr), .level_load(ll), .level_load_value(llv), .irq_pending(ip), .irq_priority(ipr),
		.irq_take(take), .user_irq_masked(msk), .cpu_priority_level(lvl), .flash_unlock_key(key),
		.flash_unlock_key_stb(stb)
	);
	// 50 MHz
	always #10 ref_clk = ~ref_clk;
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e)
		begin
			n_fail++;
			$display("mismatch %0t %h %h", $time, g, e);
		end
	endtask
	// address and data offered together, each released once taken; an edge first keeps calls apart
	task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, input logic [1:0] er = 2'h0);
		@(posedge ref_clk);
		awa <= a;
		wd <= d;
		strb <= s;
		awv <= 1'h1;
		wv <= 1'h1;
		br <= 1'h1;
		do
		begin
			@(posedge ref_clk);
			if (awr) awv <= 1'h0;
			if (wrd) wv <= 1'h0;
		end
		while (!bv);
		br <= 1'h0;
		chk(bresp, er);
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er = 2'h0);
		@(posedge ref_clk);
		ara <= a;
		arv <= 1'h1;
		rr <= 1'h1;
		do
		begin
			@(posedge ref_clk);
			if (arr) arv <= 1'h0;
		end
		while (!rv);
		rr <= 1'h0;
		chk(rdd, e);
		chk(rresp, er);
	endtask
	task automatic stop_test();
		if (n_fail == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic t_key();
		wr(4'h0, 32'h0000ffa5, 4'hf);
		chk(key, 8'ha5);
		chk(stb, 1'h1);
		rd(4'h0, 32'h0);
		chk(stb, 1'h0);
	endtask
	// every low code, all ones last so the high test starts from it
	task automatic t_low();
		for (int i = 0; i < 8; i++)
		begin
			wr(4'h4, 32'(i) << 5, 4'h1);
			rd(4'h4, 32'(i) << 5);
			chk(lvl, 32'(i));
			chk(msk, i == 7);
		end
		// even the highest request must wait at level 7
		ip <= 1'h1;
		ipr <= 4'hf;
		@(posedge ref_clk);
		chk(take, 1'h0);
	endtask
	task automatic t_high();
		ll <= 1'h1;
		llv <= 4'hc;
		ip <= 1'h1;
		ipr <= 4'hf;
		@(posedge ref_clk);
		ll <= 1'h0;
		@(posedge ref_clk);
		chk(lvl, 4'hc);
		chk({msk, take}, 2'h2);
		rd(4'h8, 32'h8);
		rd(4'h4, 32'h80);
		wr(4'h8, 32'h0, 4'h1);
		rd(4'h8, 32'h0);
		ipr <= 4'h5;
		@(posedge ref_clk);
		chk({lvl, take}, 5'h9);
		ipr <= 4'h4;
		@(posedge ref_clk);
		chk(take, 1'h0);
		ip <= 1'h0;
	endtask
	task automatic t_nest();
		wr(4'hc, 32'h8000, 4'h3);
		rd(4'hc, 32'h8000);
		wr(4'h4, 32'h20, 4'h1);
		rd(4'h4, 32'h80);
		wr(4'hc, 32'h0, 4'h3);
		wr(4'h4, 32'h20, 4'h1);
		rd(4'h4, 32'h20);
	endtask
	// unaligned offset: decode error both ways, and the status word is untouched
	task automatic t_bad();
		wr(4'h2, 32'hffffffff, 4'hf, 2'h3);
		rd(4'h2, 32'h0, 2'h3);
		rd(4'h4, 32'h20);
	endtask
	// reset in mid-run brings back idle handshakes, level zero and a cleared key
	task automatic t_rst();
		reset <= 1'h1;
		repeat (2) @(posedge ref_clk);
		reset <= 1'h0;
		@(posedge ref_clk);
		chk({awr, wrd, arr, bv, rv}, 5'h1c);
		chk({lvl, msk, key, stb}, 14'h0);
		rd(4'h4, 32'h0);
		rd(4'h8, 32'h0);
		rd(4'hc, 32'h0);
	endtask
	// hang guard, far beyond the hundred and twenty or so cycles the run needs
	initial
	begin
		#100us;
		n_fail++;
		stop_test();
	end
	initial
	begin
		repeat (5) @(posedge ref_clk);
		reset <= 1'h0;
		@(posedge ref_clk);
		rd(4'h8, 32'h0);
		t_key();
		t_low();
		t_high();
		t_nest();
		t_bad();
		t_rst();
		stop_test();
	end
endmodule
